// ### serializer_pkg.sv
// constants, states and carrier types of the embedded clock serializer
package serializer_pkg;

  // ----------------------------------------
  // symbol layout
  // ----------------------------------------
  localparam int WORD_BITS = 10;
  localparam int SYMBOL_BITS = 12;
  localparam int CLOCK_HIGH_POS = 11;
  localparam int CLOCK_LOW_POS = 0;
  localparam int DATA_LSB_POS = 1;
  localparam logic [11:0] SYNC_SYMBOL = 12'hfc0;
  localparam logic [11:0] SYMBOL_RESET = 12'h000;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int SYS_CLOCK_PERIOD_PS = 10000;
  localparam int TRANSMIT_CLOCK_MIN_PERIOD_PS = 25000;
  localparam int TRANSMIT_CLOCK_MAX_PERIOD_PS = 62500;
  localparam int LOCK_MIN_PERIODS = 510;
  localparam int LOCK_MAX_PERIODS = 2049;
  localparam int LOCK_DEFAULT_PERIODS = 1024;
  localparam int SYNC_MIN_SYMBOLS = 1024;
  localparam int LINE_RATE_MAX_MBPS = 400;
  // a clock is called halted after two of its longest periods without a rising edge
  localparam int HALT_TIMEOUT_PS = 2 * TRANSMIT_CLOCK_MAX_PERIOD_PS;
  localparam int HALT_TIMEOUT_CYCLES =
    (HALT_TIMEOUT_PS + SYS_CLOCK_PERIOD_PS - 1) / SYS_CLOCK_PERIOD_PS;

  // ----------------------------------------
  // pin synchroniser layout
  // ----------------------------------------
  localparam int PIN_COUNT = 16;
  localparam logic [15:0] PIN_RESET = 16'h0000;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_SLEEP = 2'b00,
    ST_LOCKING = 2'b01,
    ST_RUN = 2'b11
  } link_state_t;

  typedef struct packed {
    logic [11:0] symbol;
    logic strobe;
  } line_symbol_t;

endpackage

// ### symbol_framer.sv
// builds one 12-bit line symbol from a data word or the sync pattern
module symbol_framer #(
  parameter int WORD_BITS = serializer_pkg::WORD_BITS
) (
  // source
  input wire logic [WORD_BITS-1:0] word,
  input wire logic sendSync,
  // framed symbol
  output logic [serializer_pkg::SYMBOL_BITS-1:0] symbol
);

  if (WORD_BITS + 2 != serializer_pkg::SYMBOL_BITS) begin : g_bad_width
    $error("word width must leave exactly two clock bits in a symbol");
  end

  logic [serializer_pkg::SYMBOL_BITS-1:0] dataSymbol;

  // ----------------------------------------
  // framing
  // ----------------------------------------
  // clock bits framing
  assign dataSymbol = {1'b1, word, 1'b0};
  assign symbol = sendSync ? serializer_pkg::SYNC_SYMBOL : dataSymbol;

endmodule // symbol_framer

// ### embedded_clock_serializer.sv
// embedded clock serializer: capture, lock, sync and symbol framing
// Function
// - each transmit clock cycle frames one 10-bit word into a 12-bit symbol
// - lock takes 510 to 2049 transmit periods before any symbol goes out
// - either sync request high sends sync patterns instead of data
// - lock comes from sync patterns or receiver random-data locking
// - clock before power or a halted clock needs no special sequence
// - sleep input low by default keeps the device asleep and floating
// - line carries up to 400 Mbps at the top clock rate
// - word captured on rising edge when select high, else falling edge
// - drive enable low or sleep low floats the line; sleep stops lock
// - any sync request yields at least SYNC_SYMBOLS sync symbols (1024 by default), longer if held
module embedded_clock_serializer #(
  parameter int LOCK_PERIODS = serializer_pkg::LOCK_DEFAULT_PERIODS,
  parameter int SYNC_SYMBOLS = serializer_pkg::SYNC_MIN_SYMBOLS
) (
  // system
  input wire logic clock,
  input wire logic resetn,
  input wire logic clockEnable,
  // parallel side pins
  input wire logic transmitClock,
  input wire logic strobeEdgeSelect,
  input wire logic [serializer_pkg::WORD_BITS-1:0] dataWord,
  input wire logic syncRequestA,
  input wire logic syncRequestB,
  input wire logic sleepN,
  input wire logic lineDriveEnable,
  // line side
  output serializer_pkg::line_symbol_t lineOut,
  output logic lineOutputEnable,
  // status
  output logic pllLocked,
  output logic syncActive
);

  if (LOCK_PERIODS < serializer_pkg::LOCK_MIN_PERIODS ||
      LOCK_PERIODS > serializer_pkg::LOCK_MAX_PERIODS) begin : g_bad_lock
    $error("lock period count outside the allowed window");
  end
  if (SYNC_SYMBOLS < 2 || SYNC_SYMBOLS > 2047) begin : g_bad_sync
    $error("sync symbol count does not fit its counter");
  end

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rstMeta;
  logic rstn;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rstMeta <= 1'b0;
      rstn <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstn <= rstMeta;
    end
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // the data word is sampled through the same two stages as the clock, so it
  // keeps its alignment with the detected edge; it must be steady for 2 cycles
  logic [serializer_pkg::PIN_COUNT-1:0] pinRaw;
  logic [serializer_pkg::PIN_COUNT-1:0] pinMeta;
  logic [serializer_pkg::PIN_COUNT-1:0] pinSync;
  assign pinRaw = {dataWord, transmitClock, strobeEdgeSelect, syncRequestA,
                   syncRequestB, sleepN, lineDriveEnable};

  for (genvar i = 0; i < serializer_pkg::PIN_COUNT; i++) begin : g_sync
    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        pinMeta[i] <= serializer_pkg::PIN_RESET[i];
        pinSync[i] <= serializer_pkg::PIN_RESET[i];
      end else if (clockEnable) begin
        pinMeta[i] <= pinRaw[i];
        pinSync[i] <= pinMeta[i];
      end
    end
  end

  wire [serializer_pkg::WORD_BITS-1:0] wordSync = pinSync[15:6];
  wire tclkSync = pinSync[5];
  wire edgeSelSync = pinSync[4];
  wire syncAny = pinSync[3] | pinSync[2];
  wire awake = pinSync[1];
  wire driveSync = pinSync[0];

  // ----------------------------------------
  // transmit clock edges
  // ----------------------------------------
  logic tclkPrev;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tclkPrev <= 1'b0;
    end else if (clockEnable) begin
      tclkPrev <= tclkSync;
    end
  end
  wire tclkRise = tclkSync & ~tclkPrev;
  wire tclkFall = ~tclkSync & tclkPrev;
  wire captureEdge = edgeSelSync ? tclkRise : tclkFall;

  // ----------------------------------------
  // halted clock watch
  // ----------------------------------------
  logic [7:0] haltCount;
  wire halted = haltCount >= 8'(serializer_pkg::HALT_TIMEOUT_CYCLES);
  wire [7:0] next_haltCount = tclkRise ? 8'h00 : (halted ? haltCount : haltCount + 8'h01);
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      haltCount <= 8'(serializer_pkg::HALT_TIMEOUT_CYCLES);
    end else if (clockEnable) begin
      haltCount <= next_haltCount;
    end
  end

  // ----------------------------------------
  // lock state machine
  // ----------------------------------------
  serializer_pkg::link_state_t state;
  serializer_pkg::link_state_t next_state;
  logic [11:0] lockCount;
  logic [11:0] next_lockCount;
  wire lockDone = tclkRise && lockCount == 12'(LOCK_PERIODS - 1);

  always_comb begin
    next_state = state;
    next_lockCount = lockCount;
    case (state)
      serializer_pkg::ST_SLEEP: begin
        next_lockCount = 12'h000;
        if (awake) begin
          next_state = serializer_pkg::ST_LOCKING;
        end
      end
      serializer_pkg::ST_LOCKING: begin
        if (!awake) begin
          next_state = serializer_pkg::ST_SLEEP;
        // restart count on halt; the rise that ends a halt already counts
        end else if (halted && !tclkRise) begin
          next_lockCount = 12'h000;
        end else if (lockDone) begin
          next_state = serializer_pkg::ST_RUN;
        end else if (tclkRise) begin
          next_lockCount = lockCount + 12'h001;
        end
      end
      serializer_pkg::ST_RUN: begin
        next_lockCount = 12'h000;
        if (!awake) begin
          next_state = serializer_pkg::ST_SLEEP;
        end else if (halted) begin
          next_state = serializer_pkg::ST_LOCKING;
        end
      end
      default: begin
        next_state = serializer_pkg::ST_SLEEP;
        next_lockCount = 12'h000;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= serializer_pkg::ST_SLEEP;
      lockCount <= 12'h000;
    end else if (clockEnable) begin
      state <= next_state;
      lockCount <= next_lockCount;
    end
  end

  // ----------------------------------------
  // sync pattern count
  // ----------------------------------------
  logic [10:0] syncLeft;
  logic [10:0] next_syncLeft;
  wire running = state == serializer_pkg::ST_RUN;
  wire emit = running && captureEdge;
  // sync patterns let the far end lock
  wire sendSync = syncAny || syncLeft != 11'h000;

  always_comb begin
    next_syncLeft = syncLeft;
    if (emit) begin
      if (syncAny) begin
        next_syncLeft = 11'(SYNC_SYMBOLS - 1);
      end else if (syncLeft != 11'h000) begin
        next_syncLeft = syncLeft - 11'h001;
      end
    end else if (syncAny) begin
      next_syncLeft = 11'(SYNC_SYMBOLS);
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      syncLeft <= 11'h000;
    end else if (clockEnable) begin
      syncLeft <= next_syncLeft;
    end
  end

  // ----------------------------------------
  // symbol output
  // ----------------------------------------
  logic [serializer_pkg::SYMBOL_BITS-1:0] framed;
  symbol_framer #(
    .WORD_BITS(serializer_pkg::WORD_BITS)
  ) u_framer (
    .word(wordSync),
    .sendSync(sendSync),
    .symbol(framed)
  );

  // ten payload bits per transmit period set the line rate
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lineOut.symbol <= serializer_pkg::SYMBOL_RESET;
      lineOut.strobe <= 1'b0;
    end else if (clockEnable) begin
      lineOut.symbol <= emit ? framed : lineOut.symbol;
      lineOut.strobe <= emit;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lineOutputEnable <= 1'b0;
      pllLocked <= 1'b0;
      syncActive <= 1'b0;
    end else if (clockEnable) begin
      lineOutputEnable <= running && driveSync && awake;
      pllLocked <= running;
      syncActive <= running && sendSync;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_emitData;
    clockEnable && emit && !sendSync;
  endsequence

  property p_data_word;
    @(posedge clock) disable iff (!rstn)
    s_emitData |=> lineOut.strobe && lineOut.symbol[10:1] == $past(wordSync);
  endproperty
  a_data_word: assert property (p_data_word) else $error("data word not framed");

  property p_clock_bits;
    @(posedge clock) disable iff (!rstn)
    s_emitData |=> lineOut.symbol[11] == 1'b1 && lineOut.symbol[0] == 1'b0;
  endproperty
  a_clock_bits: assert property (p_clock_bits) else $error("clock bits wrong");

  property p_sync_symbol;
    @(posedge clock) disable iff (!rstn)
    clockEnable && emit && syncAny |=> lineOut.symbol == 12'hfc0 && syncActive;
  endproperty
  a_sync_symbol: assert property (p_sync_symbol) else $error("sync pattern missing");

  property p_sync_min;
    @(posedge clock) disable iff (!rstn)
    clockEnable && emit && syncAny |=> syncLeft == 11'(SYNC_SYMBOLS - 1);
  endproperty
  a_sync_min: assert property (p_sync_min) else $error("sync count not reloaded");

  property p_sync_tail;
    @(posedge clock) disable iff (!rstn)
    clockEnable && emit && !syncAny && syncLeft != 11'h000
      |=> lineOut.symbol == 12'hfc0;
  endproperty
  a_sync_tail: assert property (p_sync_tail) else $error("sync tail cut short");

  property p_lock_time;
    @(posedge clock) disable iff (!rstn)
    clockEnable && state == serializer_pkg::ST_LOCKING && awake && !halted && lockDone
      |=> state == serializer_pkg::ST_RUN ##1 pllLocked || !clockEnable;
  endproperty
  a_lock_time: assert property (p_lock_time) else $error("lock not reached on time");

  property p_no_early_symbol;
    @(posedge clock) disable iff (!rstn)
    !running |=> !lineOut.strobe;
  endproperty
  a_no_early_symbol: assert property (p_no_early_symbol) else $error("symbol before lock");

  property p_float;
    @(posedge clock) disable iff (!rstn)
    clockEnable && (!driveSync || !awake) |=> !lineOutputEnable;
  endproperty
  a_float: assert property (p_float) else $error("line driven while disabled");

  property p_sleep;
    @(posedge clock) disable iff (!rstn)
    clockEnable && !awake |=> state == serializer_pkg::ST_SLEEP ##1 !pllLocked || !clockEnable;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep did not stop lock");

  property p_halt;
    @(posedge clock) disable iff (!rstn)
    clockEnable && running && halted |=> state != serializer_pkg::ST_RUN;
  endproperty
  a_halt: assert property (p_halt) else $error("halted clock kept lock");

  property p_edge_select;
    @(posedge clock) disable iff (!rstn)
    clockEnable && running && tclkRise && !edgeSelSync |=> !lineOut.strobe;
  endproperty
  a_edge_select: assert property (p_edge_select) else $error("wrong capture edge");

endmodule // embedded_clock_serializer

// ### remote_deserializer_model.sv
// behavioural model of the remote deserializer at the far end of the line
module remote_deserializer_model (
  // system
  input wire logic clock,
  input wire logic resetn,
  // line
  input wire serializer_pkg::line_symbol_t lineOut,
  input wire logic lineOutputEnable,
  // recovered side
  output logic unlocked,
  output logic [9:0] rxWordOut,
  output logic rxValid
);
  timeunit 1ns;
  timeprecision 1ps;
  int goodRun;
  wire logic isSync = lineOut.symbol == serializer_pkg::SYNC_SYMBOL;
  wire logic framed = lineOut.symbol[11] && !lineOut.symbol[0];
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      unlocked <= 1'b1;
      goodRun <= 0;
      rxValid <= 1'b0;
      rxWordOut <= 10'h155;
    end else begin
      rxValid <= 1'b0;
      // word lines toggle while unlocked
      if (unlocked) rxWordOut <= ~rxWordOut;
      if (!lineOutputEnable) begin
        unlocked <= 1'b1;
        goodRun <= 0;
      end else if (lineOut.strobe) begin
        goodRun <= framed ? goodRun + 1 : 0;
        // lock on sync or random data
        if ((isSync && goodRun >= 3) || goodRun >= 15) unlocked <= 1'b0;
        if (!unlocked && !isSync) begin
          rxWordOut <= lineOut.symbol[10:1];
          rxValid <= 1'b1;
        end
      end
    end
  end
endmodule // remote_deserializer_model

// ### tb_embedded_clock_serializer.sv
// self-checking bench of the embedded clock serializer with its far end
module tb_embedded_clock_serializer;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  // short lock and sync counts keep the run brief
  localparam int LOCK = 510;
  localparam int SYNCS = 8;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic transmitClock = 1'b0;
  logic strobeEdgeSelect = 1'b1;
  logic [9:0] dataWord = 10'h000;
  logic syncRequestB = 1'b0;
  logic sleepN = 1'b0;
  logic lineDriveEnable = 1'b1;
  serializer_pkg::line_symbol_t lineOut;
  logic lineOutputEnable, pllLocked, syncActive, unlocked, rxValid;
  logic [9:0] rxWordOut;
  logic [9:0] capturedWord = 10'h000;
  logic prevLocked = 1'b0;
  logic [2:0][9:0] hist = 30'h0;
  logic [2:0][9:0] resendWords = 30'h0;
  int replayLeft = 0;
  int err_total = 0;
  int compares = 0;
  int lockEdges = 0, strobeCount = 0, syncRun = 0, lastRun = 0, cycles = 0;
  integer seed = 32'he9db571f;

  always #5 clock = ~clock;

  embedded_clock_serializer #(.LOCK_PERIODS(LOCK), .SYNC_SYMBOLS(SYNCS)) u_dut (
    .clock(clock), .resetn(resetn), .clockEnable(1'b1), .transmitClock(transmitClock),
    .strobeEdgeSelect(strobeEdgeSelect), .dataWord(dataWord), .syncRequestA(unlocked),
    .syncRequestB(syncRequestB), .sleepN(sleepN), .lineDriveEnable(lineDriveEnable),
    .lineOut(lineOut), .lineOutputEnable(lineOutputEnable), .pllLocked(pllLocked),
    .syncActive(syncActive)
  );
  // far-end unlocked flag drives one sync request
  remote_deserializer_model u_far (
    .clock(clock), .resetn(resetn), .lineOut(lineOut), .lineOutputEnable(lineOutputEnable),
    .unlocked(unlocked), .rxWordOut(rxWordOut), .rxValid(rxValid)
  );

  // ----------------------------------------
  // checks and expectations
  // ----------------------------------------
  task automatic check_val(input string what, input logic [11:0] exp, input logic [11:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic check_flag(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask
  task automatic check_num(input string what, input int exp, input int got);
    compares++;
    if (got != exp) begin
      err_total++;
      $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d, err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  function automatic logic [11:0] frame(input logic [9:0] w);
    return {1'b1, w, 1'b0};
  endfunction
  function automatic logic [9:0] pick_word();
    logic [9:0] w;
    w = 10'($random(seed));
    // a word framed like the sync symbol would be ambiguous on the line
    if (w == 10'h3e0) w = 10'h3e1;
    return w;
  endfunction
  // data changes on the edge opposite to capture, so it is steady around capture
  task automatic tx_periods(input int n);
    repeat (2 * n) begin
      transmitClock = ~transmitClock;
      if (transmitClock) lockEdges++;
      if (transmitClock == strobeEdgeSelect) begin
        capturedWord = dataWord;
        hist = {hist[1:0], dataWord};
      end else if (replayLeft > 0) begin
        dataWord = resendWords[replayLeft-1];
        replayLeft--;
      end else begin
        dataWord = pick_word();
      end
      // transmit period set by four system cycles per half
      repeat (4) @(negedge clock);
    end
  endtask

  // ----------------------------------------
  // line monitor
  // ----------------------------------------
  always @(negedge clock) begin
    if (resetn && lineOut.strobe === 1'b1) begin
      strobeCount++;
      check_val("clock bits", 12'h800, lineOut.symbol & 12'h801);
      if (lineOut.symbol === serializer_pkg::SYNC_SYMBOL) syncRun++;
      else begin
        check_val("data symbol", frame(capturedWord), lineOut.symbol);
        if (syncRun > 0) lastRun = syncRun;
        syncRun = 0;
      end
    end
    if (rxValid === 1'b1) check_val("far end word", {2'b00, capturedWord}, {2'b00, rxWordOut});
    if (pllLocked === 1'b1 && !prevLocked) begin
      check_num("lock edges", LOCK, lockEdges);
      check_num("symbols before lock", 0, strobeCount);
    end
    prevLocked = pllLocked;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (8) @(negedge clock);
    resetn = 1'b1;
    tx_periods(20);
    check_flag("enable while asleep", 1'b0, lineOutputEnable);
    check_flag("locked while asleep", 1'b0, pllLocked);
    check_num("symbols while asleep", 0, strobeCount);
    sleepN = 1'b1;
    repeat (4) @(negedge clock);
    lockEdges = 0;
    tx_periods(LOCK + 40);
    check_flag("far end unlocked", 1'b0, unlocked);
    for (int s = 0; s < 2; s++) begin
      strobeEdgeSelect = s[0];
      tx_periods(30);
    end
    lastRun = 0;
    syncRequestB = 1'b1;
    tx_periods(5);
    check_flag("sync selected", 1'b1, syncActive);
    check_val("sync symbol", 12'hfc0, lineOut.symbol);
    syncRequestB = 1'b0;
    tx_periods(30);
    check_flag("sync run length", 1'b1, lastRun >= SYNCS);
    lineDriveEnable = 1'b0;
    repeat (4) @(negedge clock);
    check_flag("enable with drive off", 1'b0, lineOutputEnable);
    @(negedge clock);
    check_flag("far end after float", 1'b1, unlocked);
    lineDriveEnable = 1'b1;
    tx_periods(40);
    check_flag("far end relocked", 1'b0, unlocked);
    resendWords = hist;
    replayLeft = 3;
    tx_periods(4);
    check_num("words left to resend", 0, replayLeft);
    repeat (20) @(negedge clock);
    check_flag("locked after halt", 1'b0, pllLocked);
    lockEdges = 0;
    strobeCount = 0;
    tx_periods(LOCK + 40);
    check_flag("locked after restart", 1'b1, pllLocked);
    check_flag("far end after restart", 1'b0, unlocked);
    sleepN = 1'b0;
    repeat (4) @(negedge clock);
    check_flag("enable in sleep", 1'b0, lineOutputEnable);
    tx_periods(2);
    check_flag("locked in sleep", 1'b0, pllLocked);
    end_of_test();
  end
endmodule // tb_embedded_clock_serializer
